// file: rtl/modbus_map.svh
// Constants of the serial-bus slave frame engine: function codes,
// exception codes, frame positions, limits and the CRC-16 constants.
// Assumes byte-wide traffic from a character receiver outside the block.
`ifndef MODBUS_MAP_SVH
`define MODBUS_MAP_SVH

// CRC
`define MB_CRC_INIT    16'hffff
`define MB_CRC_POLY    16'ha001
`define MB_CRC_GOOD    16'h0000

// Function codes and exception handling
`define MB_FUNC_READ   8'h03
`define MB_FUNC_WRITE  8'h10
`define MB_EXC_NONE    8'h00
`define MB_EXC_FUNC    8'h01
`define MB_EXC_ADDR    8'h02
`define MB_EXC_VALUE   8'h03
`define MB_EXC_FAIL    8'h04
`define MB_EXC_FLAG    8'h80

// Slave address range
`define MB_ADDR_MIN    8'h01
`define MB_ADDR_MAX    8'hf7

// Byte positions and lengths within a frame
`define MB_POS_FUNC    8'h01
`define MB_POS_START_H 8'h02
`define MB_POS_START_L 8'h03
`define MB_POS_CNT_H   8'h04
`define MB_POS_CNT_L   8'h05
`define MB_POS_BCNT    8'h06
`define MB_POS_WDATA   8'h07
`define MB_POS_RDATA   8'h03
`define MB_MIN_LEN     8'h04
`define MB_READ_LEN    8'h08
`define MB_WRITE_HDR   8'h09
`define MB_EXC_LEN     8'h03
`define MB_WRITE_RLEN  8'h06

// Register count limits and buffering
`define MB_READ_MAX    16'h007d
`define MB_WRITE_MAX   16'h007b
`define MB_ADDR_SPAN   17'h10000
`define MB_FIFO_DEPTH  8

`endif

// file: rtl/modbus_pkg.sv
// Types shared by the frame engine and its helpers.
// Assumes the map header supplies every numeric constant.
`default_nettype none

package modbus_pkg;

  // One received character with its end-of-frame and character-error marks
  typedef struct packed {
    logic       last;
    logic       err;
    logic [7:0] data;
  } rx_byte_type;

  // Request towards the register store
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_type;

  typedef enum logic [1:0] {S_RX, S_EXEC, S_TX} fsm_type;

  // Whole state of the frame engine
  typedef struct packed {
    fsm_type     fsm;
    logic [7:0]  idx;
    logic [15:0] crc;
    logic [7:0]  ownAddr;
    logic        addrHit;
    logic        charBad;
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] cnt;
    logic [7:0]  bcnt;
    logic [7:0]  hiByte;
    logic [7:0]  exc;
    logic [7:0]  txLen;
    logic [7:0]  txByte;
    logic [6:0]  regIdx;
    logic [15:0] regAddr;
    logic        crcErr;
    logic        accept;
  } state_type;

endpackage

`default_nettype wire

// file: rtl/crc16_step.sv
// One byte step of the CRC-16 used on the serial bus.
// Assumes a purely combinational use: the caller holds the running value.
`include "modbus_map.svh"
`timescale 1ns/1ps
`default_nettype none

module crc16_step
  import modbus_pkg::*;
(
  // Running value and new byte
  input  wire logic [15:0] crcIn,
  input  wire logic [7:0]  dataIn,
  // Value after the byte
  output logic      [15:0] crcOut
);

  // Byte in, then eight shifts with a conditional fold
  always_comb
  begin
    crcOut = crcIn ^ {8'h00, dataIn};
    for (int i = 0; i < 8; i++)
    begin
      if (crcOut[0])
        crcOut = (crcOut >> 1) ^ `MB_CRC_POLY;
      else
        crcOut = crcOut >> 1;
    end
  end

endmodule // crc16_step

`default_nettype wire

// file: rtl/frame_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; the drain side may stall for as long as it likes.
`include "modbus_map.svh"
`timescale 1ns/1ps
`default_nettype none

module frame_fifo
  import modbus_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = `MB_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   count;
  } fifo_state_type;

  if (DEPTH < 2 || WIDTH < 1)
  begin : g_check
    $error("frame_fifo: DEPTH must be at least 2 and WIDTH at least 1");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  fifo_state_type   q;
  fifo_state_type   d;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshakes: full and empty come straight from the occupancy
  assign inReady  = (q.count != (AW+1)'(DEPTH));
  assign outValid = (q.count != '0);
  assign outData  = mem[q.rd];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  // Pointer wrap is explicit so any depth of 2 or more works, not only powers of two
  always_comb
  begin
    d = q;
    if (push)
      d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + AW'(1);
    if (pop)
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + AW'(1);
    if (push && !pop)
      d.count = q.count + (AW+1)'(1);
    else if (pop && !push)
      d.count = q.count - (AW+1)'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= d;
  end

  // Storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge clk)
  begin
    if (push)
      mem[q.wr] <= inData;
  end

endmodule // frame_fifo

`default_nettype wire

// file: rtl/modbus_rtu_slave_frame_engine.sv
// Slave frame engine: parses queries, runs register reads and writes,
// builds normal and exception replies with their CRC.
// Assumes a character receiver and transmitter outside, which mark the
// last byte of a frame (line silence) and flag parity or framing errors.
`include "modbus_map.svh"
`timescale 1ns/1ps
`default_nettype none

module modbus_rtu_slave_frame_engine
  import modbus_pkg::*;
#(
  parameter int MAX_WORDS = 125
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Own slave address
  input  wire logic [7:0]  slaveAddr,
  // Received characters
  input  wire logic        rxValid,
  output logic             rxReady,
  input  wire rx_byte_type rxByte,
  // Reply characters
  output logic             txValid,
  input  wire logic        txReady,
  output logic      [7:0]  txData,
  output logic             txLast,
  // Register store
  output logic             regValid,
  output reg_req_type      regReq,
  input  wire logic        regAck,
  input  wire logic        regErr,
  input  wire logic [15:0] regRdata,
  // Status
  output logic             crcError
);

  if (MAX_WORDS < 125 || MAX_WORDS > 127)
  begin : g_check
    $error("MAX_WORDS must lie between 125 and 127");
  end

  state_type    q;
  state_type    d;
  logic [15:0]  mem [MAX_WORDS];
  logic         memWe;
  logic [6:0]   memIdx;
  logic [15:0]  memData;
  logic         popValid;
  logic         popReady;
  logic [9:0]   popWord;
  rx_byte_type  popByte;
  logic [15:0]  rxCrc;
  logic [15:0]  txCrc;
  logic [7:0]   nIdx;
  logic [7:0]   frameLen;
  logic [7:0]   wSel;
  logic [7:0]   dataOff;
  logic [7:0]   rdSel;
  logic [15:0]  rdWord;
  logic [7:0]   payloadByte;
  logic [7:0]   nextExc;
  logic         charNow;
  logic         overRange;

  // Reply length without the CRC bytes
  function automatic logic [7:0] payloadLen(input logic [7:0] exc, input logic [7:0] func,
                                            input logic [15:0] cnt);
    if (exc != `MB_EXC_NONE)
      return `MB_EXC_LEN;
    else if (func == `MB_FUNC_READ)
      return `MB_POS_RDATA + {cnt[6:0], 1'b0};
    else
      return `MB_WRITE_RLEN;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Receive buffer lets the receiver run on for up to 8 characters while a reply is pending
  frame_fifo #(
    .WIDTH ($bits(rx_byte_type)),
    .DEPTH (`MB_FIFO_DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .inData   (rxByte),
    .outValid (popValid),
    .outReady (popReady),
    .outData  (popWord)
  );

  assign popByte = rx_byte_type'(popWord);

  crc16_step u_crc_rx (
    .crcIn  (q.crc),
    .dataIn (popByte.data),
    .crcOut (rxCrc)
  );

  crc16_step u_crc_tx (
    .crcIn  (q.crc),
    .dataIn (q.txByte),
    .crcOut (txCrc)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from state
  assign txData        = q.txByte;
  assign crcError      = q.crcErr;
  assign regReq.write  = (q.func == `MB_FUNC_WRITE);
  assign regReq.addr   = q.regAddr;
  assign regReq.wdata  = mem[q.regIdx];
  assign nIdx          = q.idx + 8'h01;
  assign frameLen      = nIdx;
  assign charNow       = q.charBad | popByte.err;
  assign overRange     = ({1'b0, q.start} + {1'b0, q.cnt}) > `MB_ADDR_SPAN;

  // Next reply byte, selected by the position about to be sent
  always_comb
  begin
    dataOff = nIdx - `MB_POS_RDATA;
    rdSel   = {1'b0, dataOff[7:1]};
    rdWord  = (rdSel < 8'(MAX_WORDS)) ? mem[rdSel[6:0]] : 16'h0000;
    payloadByte = 8'h00;
    if (q.exc != `MB_EXC_NONE)
    begin
      payloadByte = (nIdx == `MB_POS_FUNC) ? (q.func | `MB_EXC_FLAG) : q.exc;
    end
    else if (q.func == `MB_FUNC_WRITE)
    begin
      case (nIdx)
        `MB_POS_FUNC:    payloadByte = q.func;
        `MB_POS_START_H: payloadByte = q.start[15:8];
        `MB_POS_START_L: payloadByte = q.start[7:0];
        `MB_POS_CNT_H:   payloadByte = q.cnt[15:8];
        default:         payloadByte = q.cnt[7:0];
      endcase
    end
    else
    begin
      // byte count then words, high byte first
      if (nIdx == `MB_POS_FUNC)
        payloadByte = q.func;
      else if (nIdx == `MB_POS_START_H)
        payloadByte = {q.cnt[6:0], 1'b0};
      else
        payloadByte = dataOff[0] ? rdWord[7:0] : rdWord[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame engine
  always_comb
  begin
    d         = q;
    d.crcErr  = 1'b0;
    d.accept  = 1'b0;
    popReady  = 1'b0;
    memWe     = 1'b0;
    memIdx    = 7'h00;
    memData   = 16'h0000;
    regValid  = 1'b0;
    txValid   = 1'b0;
    txLast    = 1'b0;
    nextExc   = `MB_EXC_NONE;
    wSel      = (q.idx - `MB_POS_WDATA) >> 1;
    case (q.fsm)
      S_RX:
      begin
        // Input stalls while a query is served, the FIFO takes the slack
        popReady = 1'b1;
        if (popValid)
        begin
          d.crc     = rxCrc;
          d.idx     = (q.idx == 8'hff) ? q.idx : nIdx;
          d.charBad = charNow;
          case (q.idx)
            8'h00:
            begin
              d.ownAddr = slaveAddr;
              d.addrHit = (popByte.data == slaveAddr) && (slaveAddr >= `MB_ADDR_MIN)
                          && (slaveAddr <= `MB_ADDR_MAX);
            end
            `MB_POS_FUNC:    d.func = popByte.data;
            `MB_POS_START_H: d.start[15:8] = popByte.data;
            `MB_POS_START_L: d.start[7:0] = popByte.data;
            `MB_POS_CNT_H:   d.cnt[15:8] = popByte.data;
            `MB_POS_CNT_L:   d.cnt[7:0] = popByte.data;
            `MB_POS_BCNT:    d.bcnt = popByte.data;
            default:         ;
          endcase
          // write values buffered until the CRC is known
          if (q.idx >= `MB_POS_WDATA && q.func == `MB_FUNC_WRITE)
          begin
            if (q.idx[0])
              d.hiByte = popByte.data;
            else if (wSel < 8'(MAX_WORDS))
            begin
              memWe   = 1'b1;
              memIdx  = wSel[6:0];
              memData = {q.hiByte, popByte.data};
            end
          end
          if (popByte.last)
          begin
            d.idx     = 8'h00;
            d.crc     = `MB_CRC_INIT;
            d.charBad = 1'b0;
            if (!charNow && frameLen >= `MB_MIN_LEN)
            begin
              // residue over frame and CRC must be zero
              if (rxCrc != `MB_CRC_GOOD)
                d.crcErr = 1'b1;
              else if (q.addrHit)
              begin
                d.accept = 1'b1;
                if (q.func == `MB_FUNC_READ)
                begin
                  if (frameLen != `MB_READ_LEN || q.cnt == 16'h0000 || q.cnt > `MB_READ_MAX)
                    nextExc = `MB_EXC_VALUE;
                  else if (overRange)
                    nextExc = `MB_EXC_ADDR;
                end
                else if (q.func == `MB_FUNC_WRITE)
                begin
                  if (q.cnt == 16'h0000 || q.cnt > `MB_WRITE_MAX
                      || q.bcnt != {q.cnt[6:0], 1'b0} || frameLen != q.bcnt + `MB_WRITE_HDR)
                    nextExc = `MB_EXC_VALUE;
                  else if (overRange)
                    nextExc = `MB_EXC_ADDR;
                end
                else
                  nextExc = `MB_EXC_FUNC;
                d.exc     = nextExc;
                d.regIdx  = 7'h00;
                d.regAddr = q.start;
                if (nextExc != `MB_EXC_NONE)
                begin
                  d.fsm    = S_TX;
                  d.txByte = q.ownAddr;
                  d.txLen  = payloadLen(nextExc, q.func, q.cnt);
                end
                else
                  d.fsm = S_EXEC;
              end
            end
          end
        end
      end
      S_EXEC:
      begin
        regValid = 1'b1;
        if (regAck)
        begin
          d.regIdx  = q.regIdx + 7'h01;
          d.regAddr = q.regAddr + 16'h0001;
          if (regErr)
          begin
            d.exc    = `MB_EXC_FAIL;
            d.fsm    = S_TX;
            d.txByte = q.ownAddr;
            d.txLen  = payloadLen(`MB_EXC_FAIL, q.func, q.cnt);
          end
          else
          begin
            if (q.func == `MB_FUNC_READ)
            begin
              memWe   = 1'b1;
              memIdx  = q.regIdx;
              memData = regRdata;
            end
            if (16'(d.regIdx) == q.cnt)
            begin
              d.fsm    = S_TX;
              d.txByte = q.ownAddr;
              d.txLen  = payloadLen(`MB_EXC_NONE, q.func, q.cnt);
            end
          end
        end
      end
      S_TX:
      begin
        // only reached through an accepted query
        txValid = 1'b1;
        txLast  = (q.idx == q.txLen + 8'h01);
        if (txReady)
        begin
          d.idx = nIdx;
          if (q.idx < q.txLen)
            d.crc = txCrc;
          if (nIdx < q.txLen)
            d.txByte = payloadByte;
          else if (nIdx == q.txLen)
            d.txByte = txCrc[7:0];
          else
            d.txByte = q.crc[15:8];
          if (txLast)
          begin
            d.fsm = S_RX;
            d.idx = 8'h00;
            d.crc = `MB_CRC_INIT;
            d.exc = `MB_EXC_NONE;
          end
        end
      end
      default:
        d.fsm = S_RX;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{fsm: S_RX, crc: `MB_CRC_INIT, default: '0};
    else
      q <= d;
  end

  // Word buffer shared by write values and read results
  always_ff @(posedge clk)
  begin
    if (memWe)
      mem[memIdx] <= memData;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_reply_after_query;
    $rose(txValid) |-> q.accept || $past(q.fsm == S_EXEC);
  endproperty
  a_reply_after_query: assert property (p_reply_after_query)
    else $error("reply started without a query");

  property p_own_match;
    q.accept |-> q.addrHit && q.ownAddr >= 8'h01 && q.ownAddr <= 8'hf7;
  endproperty
  a_own_match: assert property (p_own_match)
    else $error("query accepted for another address");

  property p_reply_addr;
    $rose(txValid) |-> txData == q.ownAddr && q.idx == 8'h00;
  endproperty
  a_reply_addr: assert property (p_reply_addr)
    else $error("reply does not open with own address");

  property p_read_count;
    (txValid && txReady && q.idx == 8'h01 && q.exc == 8'h00 && q.func == 8'h03)
      |=> txData == {q.cnt[6:0], 1'b0};
  endproperty
  a_read_count: assert property (p_read_count)
    else $error("read byte count is not twice the count");

  property p_write_echo;
    (txValid && txReady && q.idx == 8'h04 && q.exc == 8'h00 && q.func == 8'h10)
      |=> txData == q.cnt[7:0] ##1 txValid [*2];
  endproperty
  a_write_echo: assert property (p_write_echo)
    else $error("write reply does not echo the count");

  property p_exc_flag;
    (txValid && txReady && q.idx == 8'h00 && q.exc != 8'h00) |=> txData[7] && txData[6:0] == q.func[6:0];
  endproperty
  a_exc_flag: assert property (p_exc_flag)
    else $error("exception reply lacks the flagged function");

  property p_crc_drop;
    q.crcErr |-> !q.accept && q.fsm == S_RX ##1 q.fsm == S_RX;
  endproperty
  a_crc_drop: assert property (p_crc_drop)
    else $error("frame acted on despite CRC error");

  property p_crc_preset;
    (q.fsm == S_RX && q.idx == 8'h00) |-> q.crc == 16'hffff;
  endproperty
  a_crc_preset: assert property (p_crc_preset)
    else $error("CRC not preset to all ones");

  property p_crc_order;
    (txValid && txReady && q.idx == q.txLen) |=> txLast && txData == $past(q.crc[15:8]);
  endproperty
  a_crc_order: assert property (p_crc_order)
    else $error("CRC high byte not sent last");

  c_read_reply: cover property (q.accept && q.func == 8'h03 && q.fsm == S_EXEC);
  c_write_reply: cover property (txLast && txReady && q.func == 8'h10 && q.exc == 8'h00);
  c_crc_error: cover property (q.crcErr);
  c_exception: cover property (txLast && txReady && q.exc != 8'h00);

endmodule // modbus_rtu_slave_frame_engine

`default_nettype wire

// file: verif/bus_master_model.sv
// Master side of the serial bus: sends queries with their CRC and takes replies.
// Assumes the bench clock; every signal changes at the falling edge.
`timescale 1ns/1ps
`default_nettype none

module bus_master_model
  import modbus_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Query stream
  output var logic        rxValid,
  input  wire logic       rxReady,
  output var rx_byte_type rxByte,
  // Reply stream
  input  wire logic       txValid,
  output var logic        txReady,
  input  wire logic [7:0] txData,
  input  wire logic       txLast
);
  logic [7:0] rep[$];
  int         lastAt;
  logic       slow;
  logic       errChar;

  initial
  begin
    rxValid = 1'b0;
    rxByte  = '0;
    txReady = 1'b0;
    slow    = 1'b0;
    errChar = 1'b0;
  end

  function automatic logic [15:0] crcOf(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
    end
    return c;
  endfunction

  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crcOf(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(negedge clk);
      rxValid = 1'b1;
      // Character error, when asked for, marks the third byte only
      rxByte  = {i == q.size() - 1, errChar && i == 2, q[i]};
      // Held until the FIFO has room
      while (!rxReady)
        @(negedge clk);
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxByte  = {2'b00, ~rxByte.data};  // Released line shows no stale byte
  endtask

  // Takes one reply; slow mode accepts only every second cycle
  task automatic collect(input int limit);
    rep.delete();
    lastAt = -1;
    for (int n = 0; n < limit; n++)
    begin
      @(negedge clk);
      txReady = slow ? !txReady : 1'b1;
      if (txValid && txReady)
      begin
        rep.push_back(txData);
        if (txLast)
        begin
          lastAt = rep.size() - 1;
          n = limit;
        end
      end
    end
    @(negedge clk);
    txReady = 1'b0;
  endtask
endmodule // bus_master_model

`default_nettype wire

// file: verif/tb_modbus_rtu_slave_frame_engine.sv
// Bench of the slave frame engine: master model on the byte streams, a
// register store here. Assumes the design's FIFO and reply order.
`timescale 1ns/1ps
`default_nettype none

module tb_modbus_rtu_slave_frame_engine
  import modbus_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic [7:0]  slaveAddr;
  logic        rxValid;
  logic        rxReady;
  rx_byte_type rxByte;
  logic        txValid;
  logic        txReady;
  logic [7:0]  txData;
  logic        txLast;
  logic        regValid;
  reg_req_type regReq;
  logic        regAck;
  logic        regErr;
  logic [15:0] regRdata;
  logic        crcError;
  logic [15:0] errAddr;
  logic [15:0] wr[logic [15:0]];
  int          n_fail;
  int          n_tests;
  int          cyc;
  int          crcSeen;
  int          stalls;

  modbus_rtu_slave_frame_engine dut (.clk(clk), .rst_n(rst_n), .slaveAddr(slaveAddr),
    .rxValid(rxValid), .rxReady(rxReady), .rxByte(rxByte), .txValid(txValid),
    .txReady(txReady), .txData(txData), .txLast(txLast), .regValid(regValid),
    .regReq(regReq), .regAck(regAck), .regErr(regErr), .regRdata(regRdata),
    .crcError(crcError));

  bus_master_model m (.clk(clk), .rxValid(rxValid), .rxReady(rxReady), .rxByte(rxByte),
    .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast));

  ////////////////////////////////////////////////////////////////////////////////
  // Register store: answers a pending request at once; reads return a code of the address
  always @(negedge clk)
  begin
    regAck   <= regValid;
    regErr   <= regValid && (regReq.addr === errAddr);
    regRdata <= {regReq.addr[7:0], ~regReq.addr[7:0]};
    if (regValid && regReq.write)
      wr[regReq.addr] = regReq.wdata;
    if (rxValid && !rxReady)
      stalls++;
    // Pulse counted mid-cycle, where it has settled
    if (crcError === 1'b1)
      crcSeen++;
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail("timeout");
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    n_fail++;
    $display("MISMATCH %0t %s", $time, s);
  endtask

  task automatic check(input logic ok, input string s);
    n_tests++;
    if (ok !== 1'b1)
      fail(s);
  endtask

  // Reply body compared byte by byte; CRC by residue, last mark on the final byte
  task automatic cmpRep(input logic [7:0] e[$]);
    check(m.rep.size() == e.size() + 2 && m.lastAt == e.size() + 1, "reply length or last");
    check(m.crcOf(m.rep) === 16'h0000, "reply CRC");
    foreach (e[i])
      check(m.rep[i] === e[i], "reply byte");
  endtask

  // Own address changes only between frames, at a falling edge
  task automatic setAddr(input logic [7:0] a);
    slaveAddr = a;
  endtask

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tRead;
    setAddr(8'h01);
    m.slow = 1'b1;
    m.send('{8'h01, 8'h03, 8'h30, 8'h00, 8'h00, 8'h04}, 1'b0);
    m.collect(300);
    cmpRep('{8'h01, 8'h03, 8'h08, 8'h00, 8'hff, 8'h01, 8'hfe, 8'h02, 8'hfd, 8'h03,
             8'hfc});
    m.slow = 1'b0;
  endtask

  task automatic tWrite;
    setAddr(8'hf7);
    m.send('{8'hf7, 8'h10, 8'h41, 8'h10, 8'h00, 8'h02, 8'h04, 8'h00, 8'h32, 8'h00,
             8'h01}, 1'b0);
    m.collect(100);
    cmpRep('{8'hf7, 8'h10, 8'h41, 8'h10, 8'h00, 8'h02});
    check(wr[16'h4110] === 16'h0032 && wr[16'h4111] === 16'h0001, "stored words");
  endtask

  task automatic tDrop;
    int c0;
    c0 = crcSeen;
    m.send('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    m.collect(60);
    check(m.rep.size() == 0, "reply to other address");
    // Own address outside 1..247 never matches, even when the query carries it
    setAddr(8'h00);
    m.send('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    m.collect(60);
    check(m.rep.size() == 0, "reply at address 0");
    setAddr(8'hf8);
    m.send('{8'hf8, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    m.collect(60);
    check(m.rep.size() == 0, "reply at address 248");
    setAddr(8'hf7);
    // A spoiled character drops the frame without a CRC pulse
    m.errChar = 1'b1;
    m.send('{8'hf7, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
    m.collect(60);
    m.errChar = 1'b0;
    check(m.rep.size() == 0 && crcSeen == c0, "frame with bad character");
    m.send('{8'hf7, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b1);
    m.collect(60);
    check(m.rep.size() == 0 && crcSeen == c0 + 1, "bad CRC frame");
  endtask

  task automatic tExc;
    m.send('{8'hf7, 8'h07}, 1'b0);
    m.collect(100);
    cmpRep('{8'hf7, 8'h87, 8'h01});
    m.send('{8'hf7, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    m.collect(100);
    cmpRep('{8'hf7, 8'h83, 8'h03});
    m.send('{8'hf7, 8'h03, 8'h00, 8'h00, 8'h00, 8'h04}, 1'b0);
    m.collect(100);
    cmpRep('{8'hf7, 8'h83, 8'h04});
    // Block running past the top of the address space
    m.send('{8'hf7, 8'h03, 8'hff, 8'hff, 8'h00, 8'h02}, 1'b0);
    m.collect(100);
    cmpRep('{8'hf7, 8'h83, 8'h02});
    // Byte count not twice the register count: refused, nothing stored
    m.send('{8'hf7, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h04, 8'hab, 8'hcd}, 1'b0);
    m.collect(100);
    cmpRep('{8'hf7, 8'h90, 8'h03});
    check(!wr.exists(16'h0020), "refused write stored");
  endtask

  // Second query arrives while the first reply is stalled: the FIFO must buffer it, stalling the sender once full
  task automatic tFifo;
    m.send('{8'hf7, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01}, 1'b0);
    fork
      m.send('{8'hf7, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'hab, 8'hcd}, 1'b0);
      begin
        repeat (60) @(negedge clk);
        m.collect(100);
      end
    join
    cmpRep('{8'hf7, 8'h03, 8'h02, 8'h10, 8'hef});
    m.collect(100);
    cmpRep('{8'hf7, 8'h10, 8'h00, 8'h20, 8'h00, 8'h01});
    check(wr[16'h0020] === 16'habcd && stalls > 0, "buffered write");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    rst_n     = 1'b0;
    errAddr   = 16'h0002;
    regAck    = 1'b0;
    regErr    = 1'b0;
    regRdata  = 16'h0000;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    tRead();
    tWrite();
    tDrop();
    tExc();
    tFifo();
    give_verdict();
  end
endmodule // tb_modbus_rtu_slave_frame_engine

`default_nettype wire
